// ### asrc_pkg.sv
// package for the static ram access controller
// assumes a 100 MHz clock driving the controller
package asrc_pkg;
  localparam int ASRC_ADDR_W = 12;
  localparam int ASRC_DATA_W = 4;
  localparam int ASRC_CLK_PERIOD_NS = 10;
  // slowest-grade minimums and echo maximum, so any grade is met
  localparam int ASRC_READ_CYCLE_MIN_NS = 35;
  localparam int ASRC_WRITE_CYCLE_MIN_NS = 30;
  localparam int ASRC_SELECT_TO_WRITE_END_MIN_NS = 25;
  localparam int ASRC_ADDR_TO_WRITE_END_MIN_NS = 25;
  localparam int ASRC_STROBE_TO_ECHO_VALID_MAX_NS = 30;
  // least times round up
  localparam int ASRC_READ_CYC =
    (ASRC_READ_CYCLE_MIN_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;
  localparam int ASRC_WSEL_CYC =
    (ASRC_SELECT_TO_WRITE_END_MIN_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;
  localparam int ASRC_WRITE_CYC =
    (ASRC_WRITE_CYCLE_MIN_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;
  localparam logic [3:0] ASRC_CNT_ONE = 4'h1;
  typedef enum logic [2:0] {
    ASRC_IDLE  = 3'b001,
    ASRC_READ  = 3'b010,
    ASRC_WRITE = 3'b100
  } asrc_state_e;
endpackage

// ### asrc_ctrl.sv
// host-side access controller for a clockless 4k x 4 static ram
// assumes ram pins are wired straight to the outputs, read data returns via mem_dout
// How it works
// - write strobe stays high through every read cycle.
// - select and output gate held low during a read.
// - address is loaded on the same clock edge that select falls.
// - select and write strobe asserted together to write.
// - read cycle lasts at least the read cycle time.
// - write cycle lasts at least the write cycle time.
// - select held low long enough before write end.
// - address valid long enough before write end.
`timescale 1ns/1ps
module asrc_ctrl
  import asrc_pkg::*;
#(
  parameter int READ_CYC = asrc_pkg::ASRC_READ_CYC,
  parameter int WRITE_CYC = asrc_pkg::ASRC_WRITE_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [asrc_pkg::ASRC_ADDR_W-1:0] req_addr,
  input wire logic [asrc_pkg::ASRC_DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic [asrc_pkg::ASRC_DATA_W-1:0] rsp_rdata,
  output logic rsp_valid,
  output logic [asrc_pkg::ASRC_ADDR_W-1:0] mem_addr,
  output logic [asrc_pkg::ASRC_DATA_W-1:0] mem_din,
  output logic mem_sel_b,
  output logic mem_wstb_b,
  output logic mem_gate_b,
  input wire logic [asrc_pkg::ASRC_DATA_W-1:0] mem_dout
);
  import asrc_pkg::*;

  asrc_state_e state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [ASRC_ADDR_W-1:0] addr_ff;
  logic [ASRC_DATA_W-1:0] din_ff, rdata_ff;
  logic sel_b_ff, wstb_b_ff, gate_b_ff, rsp_ff;
  logic [ASRC_DATA_W-1:0] dout_s1_ff, dout_s2_ff;

  wire idle_w = (state_ff == ASRC_IDLE);
  wire take_w = idle_w && req_valid;
  wire last_w = (cnt_ff == ASRC_CNT_ONE);
  wire done_rd_w = (state_ff == ASRC_READ) && last_w;
  wire done_wr_w = (state_ff == ASRC_WRITE) && last_w;

  assign req_ready = idle_w;
  assign rsp_rdata = rdata_ff;
  assign rsp_valid = rsp_ff;
  assign mem_addr = addr_ff;
  assign mem_din = din_ff;
  assign mem_sel_b = sel_b_ff;
  assign mem_wstb_b = wstb_b_ff;
  assign mem_gate_b = gate_b_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ASRC_IDLE: begin
        if (req_valid) begin
          nxt_state = req_write ? ASRC_WRITE : ASRC_READ;
          nxt_cnt = req_write ? 4'(WRITE_CYC) : 4'(READ_CYC);
        end
      end
      ASRC_READ, ASRC_WRITE: begin
        nxt_cnt = cnt_ff - ASRC_CNT_ONE;
        if (last_w) begin
          nxt_state = ASRC_IDLE;
        end
      end
      default: begin
        nxt_state = ASRC_IDLE;
        nxt_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    dout_s1_ff <= mem_dout;
    dout_s2_ff <= dout_s1_ff;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_ff <= ASRC_IDLE;
      cnt_ff <= 4'h0;
      addr_ff <= 12'h000;
      din_ff <= 4'h0;
      rdata_ff <= 4'h0;
      rsp_ff <= 1'b0;
      sel_b_ff <= 1'b1;
      wstb_b_ff <= 1'b1;
      gate_b_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      rsp_ff <= done_rd_w;
      if (take_w) begin
        addr_ff <= req_addr;
        din_ff <= req_wdata;
      end
      if (done_rd_w) begin
        rdata_ff <= dout_s2_ff;
      end
      // strobes fall with the address register, address steady until strobes rise
      sel_b_ff <= !(take_w || (!idle_w && !last_w));
      wstb_b_ff <= !((take_w && req_write) || ((state_ff == ASRC_WRITE) && !last_w));
      gate_b_ff <= !((take_w && !req_write) || ((state_ff == ASRC_READ) && !last_w));
    end
  end

  // read phase lasts the full count
  property p_read_low;
    @(posedge clock) disable iff (!rst_b)
      (take_w && !req_write) |=> (!mem_sel_b && !mem_gate_b && mem_wstb_b) [*4];
  endproperty
  a_read_low: assert property (p_read_low) else $error("read strobes wrong");

  property p_no_wstb_read;
    @(posedge clock) disable iff (!rst_b)
      !mem_gate_b |-> mem_wstb_b;
  endproperty
  a_no_wstb_read: assert property (p_no_wstb_read) else $error("strobe low in read");

  property p_write_both;
    @(posedge clock) disable iff (!rst_b)
      !mem_wstb_b |-> !mem_sel_b;
  endproperty
  a_write_both: assert property (p_write_both) else $error("strobe without select");

  property p_write_len;
    @(posedge clock) disable iff (!rst_b)
      (take_w && req_write) |=> (!mem_wstb_b && !mem_sel_b) [*3] ##1 (mem_wstb_b && mem_sel_b);
  endproperty
  a_write_len: assert property (p_write_len) else $error("write phase length");

  property p_addr_hold;
    @(posedge clock) disable iff (!rst_b)
      (!mem_sel_b && $past(!mem_sel_b)) |-> $stable(mem_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");

  property p_addr_setup;
    @(posedge clock) disable iff (!rst_b)
      $fell(mem_sel_b) |-> (mem_addr == $past(req_addr));
  endproperty
  a_addr_setup: assert property (p_addr_setup) else $error("address not set");

  property p_read_gap;
    @(posedge clock) disable iff (!rst_b)
      $rose(mem_gate_b) |-> req_ready ##1 1'b1;
  endproperty
  a_read_gap: assert property (p_read_gap) else $error("read gap");

  property p_rsp;
    @(posedge clock) disable iff (!rst_b)
      (take_w && !req_write) |-> ##5 rsp_valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("no read response");

  property p_write_end;
    @(posedge clock) disable iff (!rst_b)
      $rose(mem_wstb_b) |-> (mem_sel_b && !$past(mem_sel_b));
  endproperty
  a_write_end: assert property (p_write_end) else $error("write end mismatch");

  // no new access taken for three cycles after one is taken
  property p_take_gap;
    @(posedge clock) disable iff (!rst_b)
      take_w |=> (!req_ready) [*3];
  endproperty
  a_take_gap: assert property (p_take_gap) else $error("access taken too soon");

  // write data steady while the strobe is low
  property p_din_hold;
    @(posedge clock) disable iff (!rst_b)
      (!mem_wstb_b && $past(!mem_wstb_b)) |-> $stable(mem_din);
  endproperty
  a_din_hold: assert property (p_din_hold) else $error("write data moved");

  // read response is a single-cycle pulse
  property p_rsp_pulse;
    @(posedge clock) disable iff (!rst_b)
      rsp_valid |=> !rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("response too long");

  // output gate only with select
  property p_gate_sel;
    @(posedge clock) disable iff (!rst_b)
      !mem_gate_b |-> !mem_sel_b;
  endproperty
  a_gate_sel: assert property (p_gate_sel) else $error("gate without select");

  // busy while the ram is selected
  property p_sel_busy;
    @(posedge clock) disable iff (!rst_b)
      !mem_sel_b |-> !req_ready;
  endproperty
  a_sel_busy: assert property (p_sel_busy) else $error("ready during access");

  // read data holds between responses
  property p_rdata_hold;
    @(posedge clock) disable iff (!rst_b)
      !rsp_valid |-> $stable(rsp_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  // address moves only as a new access starts
  property p_addr_move;
    @(posedge clock) disable iff (!rst_b)
      $changed(mem_addr) |-> $fell(mem_sel_b);
  endproperty
  a_addr_move: assert property (p_addr_move) else $error("address moved outside start");

  c_read: cover property (@(posedge clock) take_w && !req_write);
  c_write: cover property (@(posedge clock) take_w && req_write);
  c_rsp: cover property (@(posedge clock) rsp_valid);
  c_b2b: cover property (@(posedge clock) done_wr_w ##1 take_w);
  c_wr_after_rd: cover property (@(posedge clock) done_rd_w ##1 (take_w && req_write));
endmodule // asrc_ctrl

// ### asrc_ram_model.sv
// behavioural 4k x 4 static ram with split data paths
// assumes active-low select, strobe and gate from the controller
`timescale 1ns/1ps
module asrc_ram_model #(
  parameter bit ECHO = 1'b1
) (
  input wire logic [11:0] addr,
  input wire logic [3:0] din,
  input wire logic sel_b,
  input wire logic wstb_b,
  input wire logic gate_b,
  output logic [3:0] dout
);
  logic [3:0] mem [4096];
  logic [3:0] last = 4'h0;
  always @* begin
    if (!sel_b && !wstb_b) begin
      mem[addr] = din;
      dout = ECHO ? din : ~last;
      last = ECHO ? din : last;
    end else if (!sel_b && !gate_b) begin
      dout = mem[addr];
      last = mem[addr];
    end else begin
      dout = ~last;
    end
  end
endmodule // asrc_ram_model

// ### tb_top.sv
// self-checking bench for the ram access controller
// assumes the behavioural ram model on the far side
`timescale 1ns/1ps
module tb_top;
  import asrc_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [11:0] req_addr = 12'h000;
  logic [3:0] req_wdata = 4'h0;
  logic req_ready, rsp_valid, mem_sel_b, mem_wstb_b, mem_gate_b;
  logic [3:0] rsp_rdata, mem_din, mem_dout;
  logic [11:0] mem_addr;
  logic [3:0] shadow [4096];
  int fails = 0;
  int n_compared = 0;
  always #5 clock = ~clock;
  asrc_ctrl dut (.clock(clock), .rst_b(rst_b), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_rdata(rsp_rdata),
    .rsp_valid(rsp_valid), .mem_addr(mem_addr), .mem_din(mem_din), .mem_sel_b(mem_sel_b),
    .mem_wstb_b(mem_wstb_b), .mem_gate_b(mem_gate_b), .mem_dout(mem_dout));
  asrc_ram_model ram (.addr(mem_addr), .din(mem_din), .sel_b(mem_sel_b), .wstb_b(mem_wstb_b),
    .gate_b(mem_gate_b), .dout(mem_dout));
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic req(input logic w, input logic [11:0] a, input logic [3:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      n++;
      @(negedge clock);
    end
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge clock);
    req_valid = 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [3:0] d);
    int n, m;
    req(1'b1, a, d);
    shadow[a] = d;
    n = 0;
    m = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      if (mem_wstb_b === 1'b0) begin
        m++;
        chk({7'h00, mem_sel_b, mem_din}, {8'h00, d});
        chk(mem_addr, a);
        chk({8'h00, mem_dout}, {8'h00, d});
      end
      n++;
      @(negedge clock);
    end
    chk(12'(m), 12'(ASRC_WRITE_CYC));
    chk({10'h000, mem_sel_b, mem_wstb_b}, 12'h003);
  endtask
  task automatic rd(input logic [11:0] a);
    int n, m;
    req(1'b0, a, 4'h0);
    n = 0;
    m = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      if (mem_sel_b === 1'b0) begin
        m++;
        chk({9'h000, mem_wstb_b, mem_sel_b, mem_gate_b}, 12'h004);
        chk(mem_addr, a);
      end
      n++;
      @(negedge clock);
    end
    chk(12'(n), 12'(ASRC_READ_CYC));
    chk(12'(m), 12'(ASRC_READ_CYC));
    chk({8'h00, rsp_rdata}, {8'h00, shadow[a]});
    @(negedge clock);
    chk({11'h000, rsp_valid}, 12'h000);
  endtask
  task automatic test_ends();
    wr(12'h000, 4'ha);
    wr(12'hfff, 4'h5);
    rd(12'h000);
    rd(12'hfff);
    $display("test_ends done");
  endtask
  task automatic test_b2b();
    wr(12'h123, 4'h3);
    rd(12'h123);
    wr(12'h123, 4'hc);
    wr(12'h124, 4'h0);
    rd(12'h123);
    rd(12'h124);
    $display("test_b2b done");
  endtask
  initial begin
    repeat (12) @(negedge clock);
    chk({9'h000, mem_sel_b, mem_wstb_b, mem_gate_b}, 12'h007);
    rst_b = 1'b1;
    @(negedge clock);
    test_ends();
    test_b2b();
    give_verdict();
  end
  initial begin
    #20000;
    fails++;
    give_verdict();
  end
endmodule // tb_top
